// *** verilog/uart_line_modem_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ulms_defs.svh"

// What this block does
// - Parity fault set on mismatch, cleared by read
// - Framing fault set on spacing stop bit
// - Line break flag set on long spacing
// - Line status interrupt from bits one-four
// - Holding empty set on move, cleared by load
// - Holding empty interrupt, cleared by ident read
// - Transmitter idle only when both registers empty
// - Line status top bit reads zero
// - Terminal ready pin low when bit zero set
// - Request to send pin low when bit one
// - Interrupt output gated by control bit three
// - Loopback: output marking, transmit fed to receive
// - Loopback: modem pins internal, outputs forced high
// - Modem control bits two, five-seven read zero
// - Modem control reads back written value
// - Change bits set on input change, read clears
// - Status bits four-seven are inverted pins
// - Modem status interrupt on input change
// - Ring indicator only on pin falling edge
// - Change bits at zero, one, three
// - Overrun cleared by line status read
// - Data ready cleared by buffer read
// - Set during read deferred to read end, lost if flag already set
// - Loopback: request-send as CTS, ready as DSR
module uart_line_modem_status (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // CPU register bus
  input wire logic chipSelN,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire logic [2:0] addr,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOeN,
  // Line format state
  input wire logic divisorAccessBit,
  // Receiver engine events
  input wire logic rxOverrun,
  input wire logic rxParityFault,
  input wire logic rxFramingFault,
  input wire logic rxBreak,
  input wire logic rxCharLoaded,
  output logic rxSerialIn,
  // Transmitter engine
  input wire logic txShiftOut,
  input wire logic holdingMoved,
  input wire logic shifterDone,
  output logic holdingLoad,
  output logic holdingEmpty,
  // Serial pins
  input wire logic serialRxPin,
  output logic serialTxPin,
  // Modem pins
  input wire logic clearToSendN,
  input wire logic setReadyN,
  input wire logic ringN,
  input wire logic carrierDetectN,
  output logic termReadyN,
  output logic reqSendN,
  // Interrupt
  output logic irqRequest
);

  // ****************************************
  // Register state
  // ****************************************
  logic [3:0] intEnable_r;
  logic [7:0] modemControl_r;
  logic [4:0] lineFlag_r;
  logic [4:0] linePend_r;
  logic holdingEmpty_r;
  logic shifterBusy_r;
  logic holdArm_r;
  logic [7:0] dataOut_r;
  logic dataOeN_r;
  logic serialTxPin_r;
  logic rxSerialIn_r;
  logic termReadyN_r;
  logic reqSendN_r;
  logic wrActive_r;
  logic lineRead_r;
  logic bufRead_r;
  logic modemRead_r;

  // ****************************************
  // Bus decode
  // ****************************************
  wire selected = ~chipSelN;
  wire rdActive = selected & ~rdStrobeN;
  wire wrActive = selected & ~wrStrobeN;
  wire wrTake = wrActive & ~wrActive_r;
  wire lowBank = ~divisorAccessBit;
  wire hitData = (addr == `ULMS_ADDR_DATA) & lowBank;
  wire hitIntEnable = (addr == `ULMS_ADDR_INT_ENABLE) & lowBank;
  wire hitIdent = addr == `ULMS_ADDR_INT_IDENT;
  wire hitModemControl = addr == `ULMS_ADDR_MODEM_CONTROL;
  wire hitLine = addr == `ULMS_ADDR_LINE_STATUS;
  wire hitModem = addr == `ULMS_ADDR_MODEM_STATUS;
  wire ownsAddr = hitIntEnable | hitModemControl | hitLine | hitModem;

  wire lineRead = rdActive & hitLine;
  wire lineReadEnd = lineRead_r & ~lineRead;
  wire bufRead = rdActive & hitData;
  wire bufReadEnd = bufRead_r & ~bufRead;
  wire modemRead = rdActive & hitModem;
  wire modemReadEnd = modemRead_r & ~modemRead;
  wire identRead = rdActive & hitIdent;

  wire wrIntEnable = wrTake & hitIntEnable;
  wire wrModemControl = wrTake & hitModemControl;
  wire wrHolding = wrTake & hitData;

  // ****************************************
  // Modem control decode
  // ****************************************
  wire loopOn = modemControl_r[`ULMS_MC_LOOP];
  wire termReadyBit = modemControl_r[`ULMS_MC_TERM_READY];
  wire reqSendBit = modemControl_r[`ULMS_MC_REQ_SEND];
  wire irqGate = modemControl_r[`ULMS_MC_IRQ_ENABLE];
  wire [7:0] modemControlWr = dataIn & `ULMS_MC_WRITE_MASK;

  // ****************************************
  // Line status flags
  // ****************************************
  wire [4:0] lineEv = {rxBreak, rxFramingFault, rxParityFault, rxOverrun, rxCharLoaded};
  logic [4:0] lineFlagNxt;
  logic [4:0] linePendNxt;

  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1)
    begin : gLine
      ulms_pkg::ulms_step_t step;
      wire reading;
      wire readEnd;
      if (i == `ULMS_LS_DATA_READY)
      begin : gReady
        assign reading = bufRead;
        assign readEnd = bufReadEnd;
      end
      else
      begin : gError
        assign reading = lineRead;
        assign readEnd = lineReadEnd;
      end
      assign step = ulms_pkg::ulms_flag_step(lineFlag_r[i], lineEv[i], linePend_r[i], reading, readEnd);
      assign lineFlagNxt[i] = step[1];
      assign linePendNxt[i] = step[0];
    end
  endgenerate

  // ****************************************
  // Transmitter flags
  // ****************************************
  // Move wins over a load in the same cycle
  wire holdingEmptyNxt = holdingMoved | (holdingEmpty_r & ~wrHolding);
  wire shifterBusyNxt = holdingMoved | (shifterBusy_r & ~shifterDone);
  wire txIdle = holdingEmpty_r & ~shifterBusy_r;

  // ****************************************
  // Modem inputs and loopback
  // ****************************************
  wire [3:0] pinStatus = ~{carrierDetectN, ringN, setReadyN, clearToSendN};
  wire [3:0] loopStatus = {1'b0, 1'b0, termReadyBit, reqSendBit};
  wire [3:0] modemLevels = loopOn ? loopStatus : pinStatus;
  logic [7:0] modemStatus;

  ulms_modem_status uModem (
    .clk(clk),
    .nrst(nrst),
    .statusIn(modemLevels),
    .reading(modemRead),
    .readEnd(modemReadEnd),
    .modemStatus(modemStatus)
  );

  // ****************************************
  // Interrupt sources
  // ****************************************
  wire lineInt = intEnable_r[`ULMS_IEN_LINE] & (|lineFlag_r[4:1]);
  wire readyInt = intEnable_r[`ULMS_IEN_RX_DATA] & lineFlag_r[`ULMS_LS_DATA_READY];
  wire holdInt = intEnable_r[`ULMS_IEN_HOLD_EMPTY] & holdingEmpty_r & holdArm_r;
  wire modemInt = intEnable_r[`ULMS_IEN_MODEM] & (|modemStatus[3:0]);
  wire holdIdentified = holdInt & ~lineInt & ~readyInt;
  // Rearm on each new empty event or enable write
  wire holdArmNxt = holdingMoved | wrIntEnable | (holdArm_r & ~(identRead & holdIdentified));
  wire anyInt = lineInt | readyInt | holdInt | modemInt;

  // ****************************************
  // Read data
  // ****************************************
  wire [7:0] lineStatus = {1'b0, txIdle, holdingEmpty_r, lineFlag_r};
  logic [7:0] readMux;
  always_comb
  begin
    readMux = 8'h00;
    case (addr)
      `ULMS_ADDR_INT_ENABLE: readMux = {4'h0, intEnable_r};
      `ULMS_ADDR_MODEM_CONTROL: readMux = modemControl_r;
      `ULMS_ADDR_LINE_STATUS: readMux = lineStatus;
      `ULMS_ADDR_MODEM_STATUS: readMux = modemStatus;
      default: readMux = 8'h00;
    endcase
  end

  // ****************************************
  // Bus and control registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      intEnable_r <= `ULMS_RST_INT_ENABLE;
      modemControl_r <= `ULMS_RST_MODEM_CONTROL;
      wrActive_r <= 1'b0;
      lineRead_r <= 1'b0;
      bufRead_r <= 1'b0;
      modemRead_r <= 1'b0;
      dataOut_r <= 8'h00;
      dataOeN_r <= 1'b1;
    end
    else
    begin
      if (wrIntEnable)
      begin
        intEnable_r <= dataIn[3:0];
      end
      if (wrModemControl)
      begin
        modemControl_r <= modemControlWr;
      end
      wrActive_r <= wrActive;
      lineRead_r <= lineRead;
      bufRead_r <= bufRead;
      modemRead_r <= modemRead;
      dataOut_r <= readMux;
      dataOeN_r <= ~(rdActive & ownsAddr & ~(hitIntEnable & divisorAccessBit));
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lineFlag_r <= 5'h00;
      linePend_r <= 5'h00;
      holdingEmpty_r <= 1'b1;
      shifterBusy_r <= 1'b0;
      holdArm_r <= 1'b1;
    end
    else
    begin
      lineFlag_r <= lineFlagNxt;
      linePend_r <= linePendNxt;
      holdingEmpty_r <= holdingEmptyNxt;
      shifterBusy_r <= shifterBusyNxt;
      holdArm_r <= holdArmNxt;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      serialTxPin_r <= 1'b1;
      rxSerialIn_r <= 1'b1;
      termReadyN_r <= 1'b1;
      reqSendN_r <= 1'b1;
    end
    else
    begin
      serialTxPin_r <= loopOn | txShiftOut;
      rxSerialIn_r <= loopOn ? txShiftOut : serialRxPin;
      termReadyN_r <= loopOn | ~termReadyBit;
      reqSendN_r <= loopOn | ~reqSendBit;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dataOut = dataOut_r;
  assign dataOeN = dataOeN_r;
  assign holdingLoad = wrHolding;
  assign holdingEmpty = holdingEmpty_r;
  assign serialTxPin = serialTxPin_r;
  assign rxSerialIn = rxSerialIn_r;
  assign termReadyN = termReadyN_r;
  assign reqSendN = reqSendN_r;
  assign irqRequest = irqGate & anyInt;

endmodule : uart_line_modem_status

`default_nettype wire

// *** verilog/ulms_defs.svh ***
`ifndef ULMS_DEFS_SVH
`define ULMS_DEFS_SVH

// ****************************************
// Register addresses on A2..A0
// ****************************************
`define ULMS_ADDR_DATA 3'h0
`define ULMS_ADDR_INT_ENABLE 3'h1
`define ULMS_ADDR_INT_IDENT 3'h2
`define ULMS_ADDR_MODEM_CONTROL 3'h4
`define ULMS_ADDR_LINE_STATUS 3'h5
`define ULMS_ADDR_MODEM_STATUS 3'h6

// ****************************************
// Reset values
// ****************************************
`define ULMS_RST_INT_ENABLE 4'h0
`define ULMS_RST_MODEM_CONTROL 8'h00

// ****************************************
// Interrupt enable fields
// ****************************************
`define ULMS_IEN_RX_DATA 0
`define ULMS_IEN_HOLD_EMPTY 1
`define ULMS_IEN_LINE 2
`define ULMS_IEN_MODEM 3

// ****************************************
// Modem control fields and writable mask
// ****************************************
`define ULMS_MC_TERM_READY 0
`define ULMS_MC_REQ_SEND 1
`define ULMS_MC_IRQ_ENABLE 3
`define ULMS_MC_LOOP 4
`define ULMS_MC_WRITE_MASK 8'h1b

// ****************************************
// Line status fields
// ****************************************
`define ULMS_LS_DATA_READY 0
`define ULMS_LS_OVERRUN 1
`define ULMS_LS_PARITY 2
`define ULMS_LS_FRAMING 3
`define ULMS_LS_BREAK 4
`define ULMS_LS_HOLD_EMPTY 5
`define ULMS_LS_TX_IDLE 6

// ****************************************
// Modem status input order
// ****************************************
`define ULMS_MS_CTS 0
`define ULMS_MS_DSR 1
`define ULMS_MS_RING 2
`define ULMS_MS_CD 3

`endif

// *** verilog/ulms_pkg.sv ***
`default_nettype none
package ulms_pkg;

  // {flag next, pending next}
  typedef logic [1:0] ulms_step_t;

  // Sticky flag with read-deferred setting
  function automatic ulms_step_t ulms_flag_step(input logic flag, input logic ev, input logic pend,
                                                input logic reading, input logic readEnd);
    ulms_step_t res;
    res = {flag, pend};
    if (reading)
    begin
      res = {flag, pend | ev};
    end
    else if (readEnd)
    begin
      res = {(pend & ~flag) | ev, 1'b0};
    end
    else
    begin
      res = {flag | ev, 1'b0};
    end
    return res;
  endfunction : ulms_flag_step

endpackage : ulms_pkg

`default_nettype wire

// *** verilog/ulms_modem_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ulms_defs.svh"

module ulms_modem_status (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Active-high modem input levels
  input wire logic [3:0] statusIn,
  // Status register read strobe
  input wire logic reading,
  input wire logic readEnd,
  // Register image
  output logic [7:0] modemStatus
);

  logic [3:0] prev_r;
  logic primed_r;
  logic [3:0] delta_r;
  logic [3:0] pend_r;
  logic [3:0] ev;
  logic [3:0] deltaNxt;
  logic [3:0] pendNxt;

  // ****************************************
  // Change detection per input
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : gDelta
      ulms_pkg::ulms_step_t step;
      if (i == `ULMS_MS_RING)
      begin : gRing
        // Pin high-to-low only
        assign ev[i] = primed_r & statusIn[i] & ~prev_r[i];
      end
      else
      begin : gEdge
        assign ev[i] = primed_r & (statusIn[i] ^ prev_r[i]);
      end
      assign step = ulms_pkg::ulms_flag_step(delta_r[i], ev[i], pend_r[i], reading, readEnd);
      assign deltaNxt[i] = step[1];
      assign pendNxt[i] = step[0];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prev_r <= 4'h0;
      primed_r <= 1'b0;
      delta_r <= 4'h0;
      pend_r <= 4'h0;
    end
    else
    begin
      prev_r <= statusIn;
      primed_r <= 1'b1;
      delta_r <= deltaNxt;
      pend_r <= pendNxt;
    end
  end

  assign modemStatus = {statusIn, delta_r};

endmodule : ulms_modem_status

`default_nettype wire

// *** verification/ulms_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ulms_props (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire logic chipSelN,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire logic [2:0] addr,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic divisorAccessBit,
  // Serial and transmit
  input wire logic serialRxPin,
  input wire logic txShiftOut,
  input wire logic rxSerialIn,
  input wire logic serialTxPin,
  input wire logic holdingMoved,
  input wire logic holdingLoad,
  input wire logic holdingEmpty,
  // Modem pins and interrupt
  input wire logic clearToSendN,
  input wire logic setReadyN,
  input wire logic ringN,
  input wire logic carrierDetectN,
  input wire logic termReadyN,
  input wire logic reqSendN,
  input wire logic irqRequest
);
  logic rd;
  logic wr;
  logic wrTake;
  logic wrPrev_r;
  logic [7:0] mc_r;
  logic [3:0] statusLvl;
  logic rxExp;
  logic txExp;
  assign rd = !chipSelN && !rdStrobeN;
  assign wr = !chipSelN && !wrStrobeN;
  assign wrTake = wr && !wrPrev_r;
  assign statusLvl = mc_r[4] ? {2'b00, mc_r[0], mc_r[1]} : ~{carrierDetectN, ringN, setReadyN, clearToSendN};
  assign rxExp = mc_r[4] ? txShiftOut : serialRxPin;
  assign txExp = mc_r[4] | txShiftOut;
  // Shadow of the modem control register
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wrPrev_r <= 1'b0;
      mc_r <= 8'h00;
    end
    else
    begin
      wrPrev_r <= wr;
      if (wrTake && addr == 3'h4)
      begin
        mc_r <= dataIn;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_loop_tx_mark: assert property ($past(nrst) |-> serialTxPin == $past(txExp))
    else $error("serial output wrong");
  a_loop_rx_fed: assert property ($past(nrst) |-> rxSerialIn == $past(rxExp))
    else $error("receiver input wrong");
  a_term_ready_pin: assert property ((wrTake && addr == 3'h4) |-> ##2 termReadyN == !(mc_r[0] && !mc_r[4]))
    else $error("terminal ready pin wrong");
  a_req_send_pin: assert property ((wrTake && addr == 3'h4) |-> ##2 reqSendN == !(mc_r[1] && !mc_r[4]))
    else $error("request to send pin wrong");
  a_irq_gate_off: assert property ((wrTake && addr == 3'h4 && !dataIn[3]) |=> !irqRequest [*2])
    else $error("interrupt not gated");
  a_control_read_back: assert property ((rd && addr == 3'h4) |=> dataOut == ($past(mc_r) & 8'h1b))
    else $error("modem control readback wrong");
  a_status_level_bits: assert property ((rd && addr == 3'h6) |=> dataOut[7:4] == $past(statusLvl))
    else $error("modem levels wrong");
  a_line_top_zero: assert property ((rd && addr == 3'h5) |=> !dataOut[7])
    else $error("line status top bit set");
  a_hold_load_clear: assert property ((holdingLoad && !holdingMoved) |=> !holdingEmpty)
    else $error("holding empty not cleared");
  a_load_decode: assert property (holdingLoad == (wrTake && addr == 3'h0 && !divisorAccessBit))
    else $error("holding load pulse wrong");
endmodule : ulms_props
bind uart_line_modem_status ulms_props ulms_props_i (.clk(clk), .nrst(nrst), .chipSelN(chipSelN),
  .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
  .divisorAccessBit(divisorAccessBit), .serialRxPin(serialRxPin), .txShiftOut(txShiftOut),
  .rxSerialIn(rxSerialIn), .serialTxPin(serialTxPin), .holdingMoved(holdingMoved),
  .holdingLoad(holdingLoad), .holdingEmpty(holdingEmpty), .clearToSendN(clearToSendN),
  .setReadyN(setReadyN), .ringN(ringN), .carrierDetectN(carrierDetectN), .termReadyN(termReadyN),
  .reqSendN(reqSendN), .irqRequest(irqRequest));
`default_nettype wire

// *** verification/ulms_modem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ulms_modem_model #(
  parameter int LAG = 3
) (
  // Clock
  input wire logic clk,
  // Control from the channel
  input wire logic termReadyN,
  input wire logic reqSendN,
  // Status pins {carrier, ring, set ready, clear to send}
  output logic [3:0] pinN
);
  logic [LAG-1:0] dtrDly_r = '1;
  logic [LAG-1:0] rtsDly_r = '1;
  logic [1:0] line_r = 2'b11;
  // Data set echoes the control lines after a lag
  always @(posedge clk)
  begin
    dtrDly_r <= {dtrDly_r[LAG-2:0], termReadyN};
    rtsDly_r <= {rtsDly_r[LAG-2:0], reqSendN};
  end
  assign pinN = {line_r, dtrDly_r[LAG-1], rtsDly_r[LAG-1]};
  task automatic setLine(input logic [1:0] v);
    line_r <= v;
  endtask : setLine
endmodule : ulms_modem_model
`default_nettype wire

// *** verification/tb_uart_line_modem_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_uart_line_modem_status;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic chipSelN = 1'b1;
  logic rdStrobeN = 1'b1;
  logic wrStrobeN = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] dataIn = 8'h00;
  logic [6:0] ev = 7'h00;
  logic txShiftOut = 1'b1;
  logic serialRxPin = 1'b1;
  logic divisorAccessBit = 1'b0;
  logic oeSeen;
  logic [3:0] pinN;
  logic [7:0] dataOut;
  logic dataOeN, rxSerialIn, holdingLoad, holdingEmpty, serialTxPin, termReadyN, reqSendN, irqRequest;
  logic [7:0] rv;
  logic [7:0] v;
  int failCount = 0;
  int samplesChecked = 0;
  uart_line_modem_status uart_line_modem_status_i (.clk(clk), .nrst(nrst), .chipSelN(chipSelN),
    .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOeN(dataOeN), .divisorAccessBit(divisorAccessBit), .rxOverrun(ev[0]), .rxParityFault(ev[1]),
    .rxFramingFault(ev[2]), .rxBreak(ev[3]), .rxCharLoaded(ev[4]), .rxSerialIn(rxSerialIn),
    .txShiftOut(txShiftOut), .holdingMoved(ev[5]), .shifterDone(ev[6]), .holdingLoad(holdingLoad),
    .holdingEmpty(holdingEmpty), .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
    .clearToSendN(pinN[0]), .setReadyN(pinN[1]), .ringN(pinN[2]), .carrierDetectN(pinN[3]),
    .termReadyN(termReadyN), .reqSendN(reqSendN), .irqRequest(irqRequest));
  ulms_modem_model #(.LAG(3)) ulms_modem_model_i (.clk(clk), .termReadyN(termReadyN),
    .reqSendN(reqSendN), .pinN(pinN));
  always #12.5 clk = ~clk;
  // ****
  // Bus tasks
  // ****
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Active-low control pins, forced high in loopback
  function automatic logic [7:0] expPins(input logic [7:0] m);
    return {6'h00, !(m[0] && !m[4]), !(m[1] && !m[4])};
  endfunction : expPins
  // Model echoes the controls, so both modes show them as set ready and clear to send
  function automatic logic [7:0] expLevels(input logic [7:0] m);
    return {2'b00, m[0], m[1], 4'h0};
  endfunction : expLevels
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    chipSelN <= 1'b0;
    wrStrobeN <= 1'b0;
    addr <= a;
    dataIn <= d;
    @(posedge clk);
    chipSelN <= 1'b1;
    wrStrobeN <= 1'b1;
  endtask : wrReg
  // Events in e arrive while the read is active
  task automatic rdReg(input logic [2:0] a, input logic [6:0] e, output logic [7:0] d);
    @(posedge clk);
    chipSelN <= 1'b0;
    rdStrobeN <= 1'b0;
    addr <= a;
    ev <= e;
    @(posedge clk);
    ev <= 7'h00;
    #1 d = dataOut;
    oeSeen = dataOeN;
    @(posedge clk);
    chipSelN <= 1'b1;
    rdStrobeN <= 1'b1;
  endtask : rdReg
  task automatic expRd(input string what, input logic [2:0] a, input logic [7:0] e);
    rdReg(a, 7'h00, rv);
    chk(what, e, rv);
    chk("bus drive", 8'h00, {7'h0, oeSeen});
  endtask : expRd
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 7'h00;
    idle(2);
  endtask : pulse
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : giveVerdict
  initial
  begin
    idle(20000);
    failCount++;
    giveVerdict();
  end
  // ****
  // Tests
  // ****
  initial
  begin
    idle(16);
    nrst <= 1'b1;
    v = 8'($urandom(32'hb27a8b16));
    expRd("line status", 3'h5, 8'h60);
    expRd("modem control", 3'h4, 8'h00);
    expRd("modem status", 3'h6, 8'h00);
    chk("control pins", 8'h03, {6'h0, termReadyN, reqSendN});
    $display("test reset done");
    wrReg(3'h1, 8'h02);
    for (int i = 0; i < 12; i++)
    begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h10 : 8'($urandom);
      txShiftOut <= 1'($urandom);
      serialRxPin <= 1'($urandom);
      wrReg(3'h4, v);
      idle(6);
      chk("serial tx", {7'h0, v[4] | txShiftOut}, {7'h0, serialTxPin});
      chk("serial rx", {7'h0, v[4] ? txShiftOut : serialRxPin}, {7'h0, rxSerialIn});
      chk("control pins", expPins(v), {6'h0, termReadyN, reqSendN});
      chk("irq", {7'h0, v[3]}, {7'h0, irqRequest});
      expRd("modem control", 3'h4, v & 8'h1b);
      rdReg(3'h6, 7'h00, rv);
      chk("modem levels", expLevels(v), rv & 8'hf0);
    end
    wrReg(3'h4, 8'h00);
    idle(8);
    rdReg(3'h6, 7'h00, rv);
    $display("test modem control done");
    ulms_modem_model_i.setLine(2'b10);
    idle(3);
    expRd("ring fall", 3'h6, 8'h44);
    ulms_modem_model_i.setLine(2'b11);
    idle(3);
    expRd("ring rise", 3'h6, 8'h00);
    ulms_modem_model_i.setLine(2'b01);
    idle(3);
    expRd("carrier change", 3'h6, 8'h88);
    expRd("carrier held", 3'h6, 8'h80);
    ulms_modem_model_i.setLine(2'b11);
    idle(3);
    expRd("carrier drop", 3'h6, 8'h08);
    wrReg(3'h4, 8'h03);
    idle(8);
    expRd("ready and cts", 3'h6, 8'h33);
    wrReg(3'h1, 8'h08);
    wrReg(3'h4, 8'h08);
    idle(8);
    chk("modem irq", 8'h01, {7'h0, irqRequest});
    expRd("modem deltas", 3'h6, 8'h03);
    idle(2);
    chk("modem irq off", 8'h00, {7'h0, irqRequest});
    $display("test modem status done");
    wrReg(3'h1, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      pulse(7'h01 << i);
      chk("line irq", 8'h01, {7'h0, irqRequest});
      expRd("line flag", 3'h5, 8'h60 | (8'h02 << i));
      idle(2);
      chk("line irq off", 8'h00, {7'h0, irqRequest});
      expRd("line cleared", 3'h5, 8'h60);
    end
    rdReg(3'h5, 7'h02, rv);
    chk("deferred read", 8'h60, rv);
    expRd("deferred set", 3'h5, 8'h64);
    pulse(7'h02);
    rdReg(3'h5, 7'h02, rv);
    chk("set during read", 8'h64, rv);
    expRd("clear wins", 3'h5, 8'h60);
    pulse(7'h10);
    expRd("data ready", 3'h5, 8'h61);
    expRd("data ready kept", 3'h5, 8'h61);
    // Divisor bank hides the buffer and the enable register
    divisorAccessBit <= 1'b1;
    rdReg(3'h1, 7'h00, rv);
    chk("banked enable", 8'h01, {7'h0, oeSeen});
    rdReg(3'h0, 7'h00, rv);
    chk("banked buffer", 8'h01, {7'h0, oeSeen});
    expRd("banked read keeps", 3'h5, 8'h61);
    divisorAccessBit <= 1'b0;
    wrReg(3'h1, 8'h01);
    idle(1);
    chk("ready irq", 8'h01, {7'h0, irqRequest});
    rdReg(3'h0, 7'h00, rv);
    expRd("data ready cleared", 3'h5, 8'h60);
    chk("ready irq off", 8'h00, {7'h0, irqRequest});
    $display("test line status done");
    wrReg(3'h1, 8'h02);
    divisorAccessBit <= 1'b1;
    wrReg(3'h0, 8'ha5);
    expRd("banked write skipped", 3'h5, 8'h60);
    divisorAccessBit <= 1'b0;
    wrReg(3'h0, 8'h5a);
    expRd("holding loaded", 3'h5, 8'h00);
    chk("hold irq off", 8'h00, {7'h0, irqRequest});
    expRd("holding kept", 3'h5, 8'h00);
    pulse(7'h20);
    expRd("holding moved", 3'h5, 8'h20);
    chk("hold irq", 8'h01, {7'h0, irqRequest});
    rdReg(3'h2, 7'h00, rv);
    chk("ident not driven", 8'h01, {7'h0, oeSeen});
    idle(2);
    chk("ident read clears", 8'h00, {7'h0, irqRequest});
    pulse(7'h40);
    expRd("shifter done", 3'h5, 8'h60);
    $display("test transmitter done");
    giveVerdict();
  end
endmodule : tb_uart_line_modem_status
`default_nettype wire
